// ===== acc_pkg.sv
// Package for the comparator control block: register map, fields, types.
// Assumes a 32-bit classic Wishbone slave on a 200 MHz clock.
package acc_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ACC_OFS_CTRL_STATUS = 8'h00;
  localparam logic [7:0] ACC_OFS_IRQ_STATUS  = 8'h04;
  localparam logic [7:0] ACC_OFS_IRQ_MASK    = 8'h08;

  // ---------------------------------------------------------------
  // Control and status fields
  // ---------------------------------------------------------------
  localparam int ACC_BIT_ENABLE  = 0;
  localparam int ACC_BIT_SWITCH  = 1;
  localparam int ACC_POS_MODE    = 2;
  localparam int ACC_POS_INSEL   = 4;
  localparam int ACC_POS_DEST    = 8;
  localparam int ACC_BIT_POL     = 11;
  localparam int ACC_POS_HYST    = 12;
  localparam int ACC_BIT_RESULT  = 14;
  localparam int ACC_BIT_LOCK    = 15;
  localparam logic [15:0] ACC_WR_MASK   = 16'hBF7F;
  localparam logic [31:0] ACC_CS_RESET  = 32'h0000_0000;

  // Interrupt status bits: rising and falling result edges
  localparam int ACC_IRQ_RISE = 0;
  localparam int ACC_IRQ_FALL = 1;
  localparam logic [1:0] ACC_IRQ_RESET = 2'h0;

  // ---------------------------------------------------------------
  // Field encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_HYST_NONE = 2'h0, ACC_HYST_LOW = 2'h1,
    ACC_HYST_MED  = 2'h2, ACC_HYST_HIGH = 2'h3
  } acc_hyst_e;

  typedef enum logic [1:0] {
    ACC_MODE_HIGH_SPEED = 2'h0, ACC_MODE_MEDIUM = 2'h1,
    ACC_MODE_LOW_SPEED  = 2'h2, ACC_MODE_VERY_LOW = 2'h3
  } acc_mode_e;

  typedef enum logic [2:0] {
    ACC_DEST_NONE       = 3'h0, ACC_DEST_T1_BREAK   = 3'h1,
    ACC_DEST_T1_CAPTURE = 3'h2, ACC_DEST_T1_REFCLR  = 3'h3,
    ACC_DEST_RSVD4      = 3'h4, ACC_DEST_RSVD5      = 3'h5,
    ACC_DEST_T3_CAPTURE = 3'h6, ACC_DEST_T3_REFCLR  = 3'h7
  } acc_dest_e;

  // Stored configuration, grouped as sent to the analog side
  typedef struct packed {
    logic      lock;
    acc_hyst_e hyst;
    logic      pol;
    acc_dest_e dest;
    logic [2:0] insel;
    acc_mode_e mode;
    logic      sw;
    logic      en;
  } acc_cfg_s;

  // Timer destination strobes
  typedef struct packed {
    logic t1_break;
    logic t1_capture;
    logic t1_refclr;
    logic t3_capture;
    logic t3_refclr;
  } acc_route_s;

endpackage

// ===== acc_route.sv
// Polarity and output routing; purely combinational, no clock at all.
// Assumes the raw comparator result arrives straight from the analog core.
`timescale 1ns/1ps
module acc_route (
  // Comparator result and configuration
  input  wire logic             raw_i,
  input  wire logic             pol_i,
  input  wire acc_pkg::acc_dest_e dest_i,
  // Routed outputs
  output logic                  out_o,
  output acc_pkg::acc_route_s   route_o
);

  always_comb begin
    out_o   = raw_i ^ pol_i;
    route_o = '0;
    unique case (dest_i)
      acc_pkg::ACC_DEST_T1_BREAK:   route_o.t1_break   = out_o;
      acc_pkg::ACC_DEST_T1_CAPTURE: route_o.t1_capture = out_o;
      acc_pkg::ACC_DEST_T1_REFCLR:  route_o.t1_refclr  = out_o;
      acc_pkg::ACC_DEST_T3_CAPTURE: route_o.t3_capture = out_o;
      acc_pkg::ACC_DEST_T3_REFCLR:  route_o.t3_refclr  = out_o;
      acc_pkg::ACC_DEST_NONE,
      acc_pkg::ACC_DEST_RSVD4,
      acc_pkg::ACC_DEST_RSVD5:      route_o = '0;
    endcase
  end

endmodule

// ===== acc_ctrl.sv
// Comparator control block: Wishbone register bank, result sync, IRQ.
// Assumes clk_i is the gated peripheral clock and rst_i the system reset.
`timescale 1ns/1ps
module acc_ctrl (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Wishbone slave
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [7:0]          adr_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [31:0]         dat_i,
  output logic [31:0]              dat_o,
  output logic                     ack_o,
  // Analog comparator
  input  wire logic                cmp_raw_i,
  output acc_pkg::acc_cfg_s        cfg_o,
  // Unclocked output paths
  output logic                     pin_out_o,
  output logic                     event_line_o,
  output acc_pkg::acc_route_s      route_o,
  // Interrupt
  output logic                     irq_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    acc_pkg::acc_cfg_s cfg;
    logic [1:0]        sync;
    logic              result;
    logic [1:0]        irq_status;
    logic [1:0]        irq_mask;
    logic [31:0]       rdata;
    logic              ack;
    logic              irq;
  } acc_state_s;

  acc_state_s st;
  acc_state_s next_st;

  logic cmp_out;

  // ---------------------------------------------------------------
  // Clock free output path
  // ---------------------------------------------------------------
  acc_route u_route (
    .raw_i   (cmp_raw_i),
    .pol_i   (st.cfg.pol),
    .dest_i  (st.cfg.dest),
    .out_o   (cmp_out),
    .route_o (route_o)
  );

  // Pin and event line see the same polarity-adjusted output
  assign pin_out_o    = cmp_out;
  assign event_line_o = cmp_out;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] cs_word(input acc_pkg::acc_cfg_s c,
                                          input logic res);
    logic [31:0] w;
    w = acc_pkg::ACC_CS_RESET;
    w[acc_pkg::ACC_BIT_ENABLE]          = c.en;
    w[acc_pkg::ACC_BIT_SWITCH]          = c.sw;
    w[acc_pkg::ACC_POS_MODE +: 2]       = c.mode;
    w[acc_pkg::ACC_POS_INSEL +: 3]      = c.insel;
    w[acc_pkg::ACC_POS_DEST +: 3]       = c.dest;
    w[acc_pkg::ACC_BIT_POL]             = c.pol;
    w[acc_pkg::ACC_POS_HYST +: 2]       = c.hyst;
    w[acc_pkg::ACC_BIT_RESULT]          = res;
    w[acc_pkg::ACC_BIT_LOCK]            = c.lock;
    return w;
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic        req;
  logic        wr;
  logic [31:0] wmerge;
  logic [31:0] cs_merge;
  logic [15:0] cs_new;
  logic [1:0]  ev;

  always_comb begin
    next_st = st;
    req     = cyc_i && stb_i && !st.ack;
    wr      = req && we_i;
    wmerge  = byte_merge(32'h0000_0000, dat_i, sel_i);
    cs_merge = byte_merge(cs_word(st.cfg, 1'b0), dat_i, sel_i);
    cs_new  = 16'h0000;

    // Two-stage synchroniser; stage 0 feeds only stage 1
    next_st.sync   = {st.sync[0], cmp_raw_i};
    next_st.result = st.sync[1];

    // Result edge events
    ev = 2'h0;
    ev[acc_pkg::ACC_IRQ_RISE] = st.sync[1] && !st.result;
    ev[acc_pkg::ACC_IRQ_FALL] = !st.sync[1] && st.result;

    next_st.ack = req;

    if (wr && adr_i == acc_pkg::ACC_OFS_CTRL_STATUS) begin
      // Locked writes dropped, still acknowledged
      if (!st.cfg.lock) begin
        cs_new = cs_merge[15:0] & acc_pkg::ACC_WR_MASK;
        next_st.cfg.en    = cs_new[acc_pkg::ACC_BIT_ENABLE];
        next_st.cfg.sw    = cs_new[acc_pkg::ACC_BIT_SWITCH];
        next_st.cfg.mode  =
          acc_pkg::acc_mode_e'(cs_new[acc_pkg::ACC_POS_MODE +: 2]);
        next_st.cfg.insel = cs_new[acc_pkg::ACC_POS_INSEL +: 3];
        next_st.cfg.dest  =
          acc_pkg::acc_dest_e'(cs_new[acc_pkg::ACC_POS_DEST +: 3]);
        next_st.cfg.pol   = cs_new[acc_pkg::ACC_BIT_POL];
        next_st.cfg.hyst  =
          acc_pkg::acc_hyst_e'(cs_new[acc_pkg::ACC_POS_HYST +: 2]);
        next_st.cfg.lock  = cs_new[acc_pkg::ACC_BIT_LOCK];
      end
    end

    if (wr && adr_i == acc_pkg::ACC_OFS_IRQ_MASK) begin
      next_st.irq_mask = wmerge[1:0];
    end

    // Write one to clear; a new event wins over the clear
    if (wr && adr_i == acc_pkg::ACC_OFS_IRQ_STATUS) begin
      next_st.irq_status = st.irq_status & ~wmerge[1:0];
    end
    next_st.irq_status = next_st.irq_status | ev;

    next_st.irq = |(next_st.irq_status & next_st.irq_mask);

    // Read data; unmapped addresses read zero
    next_st.rdata = 32'h0000_0000;
    if (req && !we_i) begin
      unique case (adr_i)
        acc_pkg::ACC_OFS_CTRL_STATUS:
          next_st.rdata = cs_word(st.cfg, st.result);
        acc_pkg::ACC_OFS_IRQ_STATUS:
          next_st.rdata = {30'h0, st.irq_status};
        acc_pkg::ACC_OFS_IRQ_MASK:
          next_st.rdata = {30'h0, st.irq_mask};
        default:
          next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st            <= '0;
      st.irq_status <= acc_pkg::ACC_IRQ_RESET;
      st.irq_mask   <= acc_pkg::ACC_IRQ_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign dat_o = st.rdata;
  assign ack_o = st.ack;
  assign cfg_o = st.cfg;
  assign irq_o = st.irq;

endmodule

// ===== acc_ctrl_assertions.sv
// Checker for acc_ctrl: bus timing, lock, routing and read-back.
// Bound to acc_ctrl ports from tb_top; one clock domain.
`timescale 1ns/1ps
module acc_ctrl_chk (
  // Clock, reset and bus
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                cyc_i,
  input wire logic                stb_i,
  input wire logic                we_i,
  input wire logic [7:0]          adr_i,
  input wire logic [31:0]         dat_o,
  input wire logic                ack_o,
  // Comparator side
  input wire logic                cmp_raw_i,
  input wire acc_pkg::acc_cfg_s   cfg_o,
  input wire logic                pin_out_o,
  input wire logic                event_line_o,
  input wire acc_pkg::acc_route_s route_o
);
  logic [4:0] exp_rt;
  assign exp_rt = {cfg_o.dest == 3'h1, cfg_o.dest == 3'h2,
    cfg_o.dest == 3'h3, cfg_o.dest == 3'h6, cfg_o.dest == 3'h7}
    & {5{pin_out_o}};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence rd_cs;
    ack_o && !we_i && adr_i == 8'h00;
  endsequence
  sequence raw_steady;
    $stable(cmp_raw_i) [*5];
  endsequence
  chk_ack_next:
  assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack not a single cycle after request");
  chk_lock_sticky:
  assert property (cfg_o.lock |=> cfg_o.lock) else $error("lock cleared");
  chk_lock_frozen:
  assert property (cfg_o.lock |=> $stable(cfg_o))
    else $error("locked config changed");
  chk_reset_zero:
  assert property ($fell(rst_i) |-> cfg_o == '0)
    else $error("config not zero after reset");
  chk_pol_out:
  assert property (pin_out_o == (cmp_raw_i ^ cfg_o.pol))
    else $error("pin output polarity wrong");
  chk_event_line:
  assert property (event_line_o == pin_out_o) else $error("event line wrong");
  chk_route_sel:
  assert property (route_o == exp_rt) else $error("route strobes wrong");
  chk_result_bit:
  assert property (raw_steady ##0 rd_cs |-> dat_o[14] == cmp_raw_i)
    else $error("result bit wrong");
  chk_read_back:
  assert property (rd_cs |-> dat_o[31:16] == 16'h0000 && !dat_o[7] &&
    {dat_o[15], dat_o[13:8], dat_o[6:0]} == cfg_o)
    else $error("read-back differs from config");
endmodule

// ===== acc_far.sv
// Far-side model: timer inputs and event controller edge counters.
// Assumes strobes come unclocked from acc_ctrl; counts rising edges.
`timescale 1ns/1ps
module acc_far (
  // Observed lines
  input  wire acc_pkg::acc_route_s route_i,
  input  wire logic                event_i,
  // Edge counts
  output int                       ev_cnt = 0,
  output int                       rt_cnt = 0
);
  // No bus clock here: edges are caught as they come
  always @(posedge event_i) ev_cnt++;
  always @(posedge (|route_i)) rt_cnt++;
endmodule

// ===== tb_top.sv
// Testbench for acc_ctrl: register model, routing and interrupt checks.
// Assumes acc_pkg, acc_route, acc_ctrl, acc_far and checker compiled.
`timescale 1ns/1ps
module tb_top;
  logic                clk_i = 1'b0;
  logic                rst_i = 1'b1;
  logic                cyc_i = 1'b0;
  logic                stb_i = 1'b0;
  logic                we_i = 1'b0;
  logic                cmp_raw_i = 1'b0;
  logic [7:0]          adr_i = 8'h00;
  logic [3:0]          sel_i = 4'h0;
  logic [31:0]         dat_i = 32'h0;
  logic [31:0]         seed = 32'h0000_0580;
  logic [31:0]         dat_o, rd, v;
  logic                ack_o, pin_out_o, event_line_o, irq_o;
  acc_pkg::acc_cfg_s   cfg_o;
  acc_pkg::acc_route_s route_o;
  int                  error_cnt = 0, cmp_count = 0, cs, d, i, e0, r0;
  int                  ev_cnt, rt_cnt;
  always #2.5 clk_i = ~clk_i;
  acc_ctrl u_acc_ctrl (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .cmp_raw_i, .cfg_o, .pin_out_o,
    .event_line_o, .route_o, .irq_o);
  acc_far u_acc_far (.route_i(route_o), .event_i(event_line_o), .ev_cnt,
    .rt_cnt);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One classic cycle; called just after a rising edge
  task automatic wb(logic w, logic [7:0] a, logic [31:0] x, logic [3:0] s);
    int n;
    n = 0;
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, x, s};
    do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 50);
    if (n >= 50) error_cnt++;
    rd = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic wr_cs(logic [31:0] x, logic [3:0] s);
    int m;
    m = {{8{s[1]}}, {8{s[0]}}} & acc_pkg::ACC_WR_MASK;
    wb(1'b1, acc_pkg::ACC_OFS_CTRL_STATUS, x, s);
    if (!cs[15]) cs = (cs & ~m) | (x[15:0] & m);
  endtask
  task automatic rd_cs;
    wb(1'b0, acc_pkg::ACC_OFS_CTRL_STATUS, 32'h0, 4'hF);
    check("cs", rd, {16'h0, cs[15], cmp_raw_i, cs[13:0]});
    check("cfg", cfg_o, {cs[15], cs[13:8], cs[6:0]});
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    cs = 0;
    rd_cs;
    for (i = 0; i < 14; i++) begin
      v = (i < 8) ? i * 32'h1111 | (i & 3) << 2 : rnd() & 32'hFFFF7FFF;
      cmp_raw_i <= v[20] ^ v[0];
      wr_cs(v, 4'hF);
      repeat (4) @(posedge clk_i);
      rd_cs;
    end
    cmp_raw_i <= 1'b0;
    for (d = 0; d < 8; d++) begin
      wr_cs(d << 8 | 32'h0800, 4'h2);
      {e0, r0} = {ev_cnt, rt_cnt};
      cmp_raw_i <= 1'b1;
      @(posedge clk_i);
      cmp_raw_i <= 1'b0;
      @(posedge clk_i);
      check("event", ev_cnt - e0, 1);
      check("route", rt_cnt - r0, !(d inside {0, 4, 5}));
    end
    repeat (6) @(posedge clk_i);
    wb(1'b1, acc_pkg::ACC_OFS_IRQ_STATUS, 32'h3, 4'hF);
    wb(1'b1, acc_pkg::ACC_OFS_IRQ_MASK, 32'h1, 4'hF);
    cmp_raw_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    check("irq", irq_o, 1);
    wb(1'b1, acc_pkg::ACC_OFS_IRQ_STATUS, 32'h1, 4'hF);
    cmp_raw_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    check("irq", irq_o, 0);
    wb(1'b0, acc_pkg::ACC_OFS_IRQ_STATUS, 32'h0, 4'hF);
    check("status", rd, 2);
    wb(1'b1, 8'h0C, 32'hFFFF, 4'hF);
    check("unmapped", rd, 0);
    wb(1'b0, 8'h0C, 32'h0, 4'hF);
    check("unmapped", rd, 0);
    wr_cs(32'h8A35, 4'hF);
    wr_cs(32'h0000, 4'hF);
    rd_cs;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    cs = 0;
    rd_cs;
    test_done;
  end
  initial begin
    #20000;
    error_cnt++;
    test_done;
  end
endmodule
bind acc_ctrl acc_ctrl_chk u_acc_ctrl_chk (.clk_i, .rst_i, .cyc_i, .stb_i,
  .we_i, .adr_i, .dat_o, .ack_o, .cmp_raw_i, .cfg_o, .pin_out_o,
  .event_line_o, .route_o);
